// ### hdl/brse_evaluator.v
// Boolean rung stack evaluator: contact logic, stack, coils, immediate I/O
`timescale 1ns/1ps
`default_nettype none
`include "brse_defines.vh"
module brse_evaluator (
   input wire clock_i,
   input wire srst_i,
   input wire scan_start_i,
   input wire instr_valid_i,
   input wire [`BRSE_OP_W-1:0] instr_op_i,
   input wire [`BRSE_MOD_W-1:0] instr_mod_i,
   input wire [`BRSE_ADDR_W-1:0] instr_addr_i,
   input wire rung_start_i,
   input wire [`BRSE_VAL_W-1:0] cmp_a_i,
   input wire [`BRSE_VAL_W-1:0] cmp_b_i,
   input wire [`BRSE_POINTS-1:0] field_in_i,
   output wire instr_ready_o,
   output reg [`BRSE_POINTS-1:0] field_out_o,
   output reg imm_out_we_o,
   output reg [`BRSE_ADDR_W-1:0] imm_out_addr_o,
   output reg imm_out_data_o,
   output reg imm_in_rd_o,
   output reg [`BRSE_ADDR_W-1:0] imm_in_addr_o,
   output reg rung_result_o,
   output reg stack_error_o,
   output reg scan_done_o,
   output reg executing_o
);
   // Scan phases
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_INPUT = 3'h1;
   localparam [2:0] ST_EXEC = 3'h2;
   localparam [2:0] ST_FETCH = 3'h3;
   localparam [2:0] ST_IMM = 3'h4;
   localparam [2:0] ST_OUTPUT = 3'h5;
   localparam integer IMM_CYC_I = `BRSE_IMM_CYC;
   localparam integer DEPTH_I = `BRSE_DEPTH;
   localparam [`BRSE_WAIT_W-1:0] IMM_WAIT = IMM_CYC_I[`BRSE_WAIT_W-1:0];
   localparam [`BRSE_DEPTH_W-1:0] DEPTH_MAX = DEPTH_I[`BRSE_DEPTH_W-1:0];
   localparam [`BRSE_DEPTH_W-1:0] DEPTH_ONE = 4'h1;

   reg [2:0] state;
   reg [2:0] next_state;
   reg [`BRSE_DEPTH-1:0] stack;
   reg [`BRSE_DEPTH_W-1:0] depth;
   reg [`BRSE_WAIT_W-1:0] wait_cnt;
   reg [`BRSE_OP_W-1:0] held_op;
   reg [`BRSE_MOD_W-1:0] held_mod;
   reg [`BRSE_ADDR_W-1:0] held_addr;
   reg held_rung;
   wire img_bit;
   wire [`BRSE_ADDR_W-1:0] img_rd_addr;
   wire [`BRSE_POINTS-1:0] img_all;
   reg img_load;
   reg img_we;
   reg img_wd;

   // Applies a contact to the stack top by opcode class
   function [`BRSE_DEPTH-1:0] apply_contact;
      input [`BRSE_DEPTH-1:0] stk;
      input [1:0] how;
      input c;
      begin
         apply_contact = stk;
         case (how)
            2'h0: apply_contact = {stk[`BRSE_DEPTH-2:0], c};
            2'h1: apply_contact[0] = stk[0] & c;
            2'h2: apply_contact[0] = stk[0] | c;
            default: apply_contact = stk;
         endcase
      end
   endfunction

   // Relation of two BCD values; plain binary order matches BCD order
   function compare_rel;
      input [`BRSE_MOD_W-1:0] rel;
      input [`BRSE_VAL_W-1:0] a;
      input [`BRSE_VAL_W-1:0] b;
      begin
         case (rel)
            `BRSE_REL_EQ: compare_rel = (a == b);
            `BRSE_REL_NE: compare_rel = (a != b);
            `BRSE_REL_GE: compare_rel = (a >= b);
            default: compare_rel = (a < b);
         endcase
      end
   endfunction

   // Address the image at the take edge so the bit is ready during fetch
   assign img_rd_addr = (state == ST_EXEC) ? instr_addr_i : held_addr;

   // Image read data stands in the fetch cycle after the take
   brse_image u_image (
      .clock_i(clock_i),
      .srst_i(srst_i),
      .load_all_i(img_load),
      .load_data_i(field_in_i),
      .wr_en_i(img_we),
      .wr_addr_i(held_addr),
      .wr_data_i(img_wd),
      .rd_addr_i(img_rd_addr),
      .rd_data_o(img_bit),
      .all_o(img_all)
   );

   // Instructions are accepted only while executing and not stalled
   assign instr_ready_o = (state == ST_EXEC);

   // Next phase of the scan
   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: if (scan_start_i) next_state = ST_INPUT;
         ST_INPUT: next_state = ST_EXEC;
         ST_EXEC: begin
            if (instr_valid_i) begin
               if (instr_op_i == `BRSE_OP_END) begin
                  next_state = ST_OUTPUT;
               end else if (instr_op_i >= `BRSE_OP_IMM_LD) begin
                  next_state = ST_IMM;
               end else begin
                  next_state = ST_FETCH;
               end
            end
         end
         ST_FETCH: next_state = ST_EXEC;
         ST_IMM: if (wait_cnt == IMM_WAIT) next_state = ST_EXEC;
         ST_OUTPUT: next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
   end

   // Image writes: bulk load at input update, coil writes at completion
   always @* begin
      img_load = (state == ST_INPUT);
      img_we = 1'b0;
      img_wd = stack[0];
      if (state == ST_FETCH && held_op == `BRSE_OP_COIL) begin
         img_we = 1'b1;
      end
      if (state == ST_IMM && wait_cnt == IMM_WAIT &&
          held_op == `BRSE_OP_IMM_COIL) begin
         img_we = 1'b1;
      end
   end

   // Scan sequencing, stack and physical access
   always @(posedge clock_i) begin
      if (srst_i) begin
         state <= ST_IDLE;
         stack <= {`BRSE_DEPTH{1'b0}};
         depth <= {`BRSE_DEPTH_W{1'b0}};
         wait_cnt <= {`BRSE_WAIT_W{1'b0}};
         held_op <= `BRSE_OP_NOP;
         held_mod <= {`BRSE_MOD_W{1'b0}};
         held_addr <= {`BRSE_ADDR_W{1'b0}};
         held_rung <= 1'b0;
         field_out_o <= {`BRSE_POINTS{1'b0}};
         imm_out_we_o <= 1'b0;
         imm_out_addr_o <= {`BRSE_ADDR_W{1'b0}};
         imm_out_data_o <= 1'b0;
         imm_in_rd_o <= 1'b0;
         imm_in_addr_o <= {`BRSE_ADDR_W{1'b0}};
         rung_result_o <= 1'b0;
         stack_error_o <= 1'b0;
         scan_done_o <= 1'b0;
         executing_o <= 1'b0;
      end else begin
         state <= next_state;
         scan_done_o <= 1'b0;
         imm_out_we_o <= 1'b0;
         imm_in_rd_o <= 1'b0;
         executing_o <= (next_state == ST_EXEC) ||
                        (next_state == ST_FETCH) || (next_state == ST_IMM);
         rung_result_o <= stack[0];
         case (state)
            ST_IDLE: begin
               if (scan_start_i) begin
                  stack <= {`BRSE_DEPTH{1'b0}};
                  depth <= {`BRSE_DEPTH_W{1'b0}};
                  stack_error_o <= 1'b0;
               end
            end
            ST_EXEC: begin
               if (instr_valid_i) begin
                  held_op <= instr_op_i;
                  held_mod <= instr_mod_i;
                  held_addr <= instr_addr_i;
                  held_rung <= rung_start_i;
                  wait_cnt <= {`BRSE_WAIT_W{1'b0}};
                  if (instr_op_i >= `BRSE_OP_IMM_LD &&
                      instr_op_i != `BRSE_OP_END) begin
                     // Strobe every time; no cached value is reused
                     if (instr_op_i == `BRSE_OP_IMM_COIL) begin
                        imm_out_we_o <= 1'b1;
                        imm_out_addr_o <= instr_addr_i;
                        imm_out_data_o <= stack[0];
                     end else begin
                        imm_in_rd_o <= 1'b1;
                        imm_in_addr_o <= instr_addr_i;
                     end
                  end
               end
            end
            ST_FETCH: begin
               case (held_op)
                  `BRSE_OP_LD_OPEN, `BRSE_OP_LD_CLOSED, `BRSE_OP_CMP: begin
                     if (held_rung) begin
                        // Fresh rung: only the new entry remains
                        stack <= {{(`BRSE_DEPTH-1){1'b0}},
                                  (held_op == `BRSE_OP_CMP) ?
                                  compare_rel(held_mod, cmp_a_i, cmp_b_i) :
                                  (img_bit ^ (held_op ==
                                  `BRSE_OP_LD_CLOSED))};
                        depth <= DEPTH_ONE;
                     end else begin
                        if (depth == DEPTH_MAX) begin
                           stack_error_o <= 1'b1;
                        end else begin
                           depth <= depth + DEPTH_ONE;
                        end
                        stack <= apply_contact(stack, 2'h0,
                           (held_op == `BRSE_OP_CMP) ?
                           compare_rel(held_mod, cmp_a_i, cmp_b_i) :
                           (img_bit ^ (held_op ==
                           `BRSE_OP_LD_CLOSED)));
                     end
                  end
                  `BRSE_OP_SER: stack <= apply_contact(stack, 2'h1,
                                                       img_bit);
                  `BRSE_OP_SER_NOT: stack <= apply_contact(stack, 2'h1,
                                                           ~img_bit);
                  `BRSE_OP_PAR: stack <= apply_contact(stack, 2'h2,
                                                       img_bit);
                  `BRSE_OP_PAR_NOT: stack <= apply_contact(stack, 2'h2,
                                                           ~img_bit);
                  `BRSE_OP_PAR_MERGE, `BRSE_OP_SER_MERGE: begin
                     // Flags a stack error unless both branches have been loaded
                     if (depth > DEPTH_ONE) begin
                        stack <= {1'b0, stack[`BRSE_DEPTH-1:2],
                           (held_op == `BRSE_OP_PAR_MERGE) ?
                           (stack[0] | stack[1]) :
                           (stack[0] & stack[1])};
                        depth <= depth - DEPTH_ONE;
                     end else begin
                        stack_error_o <= 1'b1;
                     end
                  end
                  // Coil leaves the stack untouched for midline use
                  `BRSE_OP_COIL: stack <= stack;
                  default: stack <= stack;
               endcase
            end
            ST_IMM: begin
               wait_cnt <= wait_cnt + 4'h1;
               if (wait_cnt == IMM_WAIT) begin
                  // Physical value used for this one step only
                  case (held_op)
                     `BRSE_OP_IMM_LD: begin
                        if (depth == DEPTH_MAX) begin
                           stack_error_o <= 1'b1;
                        end else begin
                           depth <= depth + DEPTH_ONE;
                        end
                        stack <= apply_contact(stack, 2'h0,
                           field_in_i[held_addr] ^ held_mod[0]);
                     end
                     `BRSE_OP_IMM_SER: stack <= apply_contact(stack, 2'h1,
                        field_in_i[held_addr] ^ held_mod[0]);
                     `BRSE_OP_IMM_PAR: stack <= apply_contact(stack, 2'h2,
                        field_in_i[held_addr] ^ held_mod[0]);
                     default: stack <= stack;
                  endcase
               end
            end
            ST_OUTPUT: begin
               field_out_o <= img_all;
               scan_done_o <= 1'b1;
            end
            default: stack <= stack;
         endcase
      end
   end
endmodule // brse_evaluator
`default_nettype wire

// ### hdl/brse_defines.vh
// Constants shared by the boolean rung stack evaluator
`ifndef BRSE_DEFINES_VH
`define BRSE_DEFINES_VH
// Opcode field of the instruction word
`define BRSE_OP_W 4
`define BRSE_OP_NOP 4'h0
`define BRSE_OP_LD_OPEN 4'h1
`define BRSE_OP_LD_CLOSED 4'h2
`define BRSE_OP_SER 4'h3
`define BRSE_OP_SER_NOT 4'h4
`define BRSE_OP_PAR 4'h5
`define BRSE_OP_PAR_NOT 4'h6
`define BRSE_OP_PAR_MERGE 4'h7
`define BRSE_OP_SER_MERGE 4'h8
`define BRSE_OP_COIL 4'h9
`define BRSE_OP_CMP 4'hA
`define BRSE_OP_IMM_LD 4'hB
`define BRSE_OP_IMM_SER 4'hC
`define BRSE_OP_IMM_PAR 4'hD
`define BRSE_OP_IMM_COIL 4'hE
`define BRSE_OP_END 4'hF
// Modifier field: bit 0 inverts an immediate contact, bits 1:0 pick a relation
`define BRSE_MOD_W 2
`define BRSE_REL_EQ 2'h0
`define BRSE_REL_NE 2'h1
`define BRSE_REL_GE 2'h2
`define BRSE_REL_LT 2'h3
// Point addressing and image size
`define BRSE_ADDR_W 6
`define BRSE_POINTS 64
// Boolean stack depth
`define BRSE_DEPTH 8
`define BRSE_DEPTH_W 4
// Comparison operands, four BCD digits
`define BRSE_VAL_W 16
// Physical point access latency
`define BRSE_IMM_NS 100
`define BRSE_CLK_NS 25
`define BRSE_IMM_CYC ((`BRSE_IMM_NS + `BRSE_CLK_NS - 1) / `BRSE_CLK_NS)
`define BRSE_WAIT_W 4
`endif

// ### hdl/brse_image.v
// Image register: one bit per point, registered read port
`timescale 1ns/1ps
`default_nettype none
`include "brse_defines.vh"
module brse_image (
   input wire clock_i,
   input wire srst_i,
   input wire load_all_i,
   input wire [`BRSE_POINTS-1:0] load_data_i,
   input wire wr_en_i,
   input wire [`BRSE_ADDR_W-1:0] wr_addr_i,
   input wire wr_data_i,
   input wire [`BRSE_ADDR_W-1:0] rd_addr_i,
   output reg rd_data_o,
   output wire [`BRSE_POINTS-1:0] all_o
);
   reg [`BRSE_POINTS-1:0] bits;
   assign all_o = bits;
   // Bulk load is the input update; single writes come from coils
   always @(posedge clock_i) begin
      if (srst_i) begin
         bits <= {`BRSE_POINTS{1'b0}};
         rd_data_o <= 1'b0;
      end else begin
         if (load_all_i) begin
            bits <= load_data_i;
         end else if (wr_en_i) begin
            bits[wr_addr_i] <= wr_data_i;
         end
         rd_data_o <= bits[rd_addr_i];
      end
   end
endmodule // brse_image
`default_nettype wire

// ### verification/brse_evaluator_asserts.sv
// Port-level timing checks for the rung stack evaluator
`timescale 1ns/1ps
`default_nettype none
`include "brse_defines.vh"
module brse_evaluator_chk (
   input wire clock_i,
   input wire srst_i,
   input wire scan_start_i,
   input wire instr_valid_i,
   input wire [`BRSE_OP_W-1:0] instr_op_i,
   input wire [`BRSE_ADDR_W-1:0] instr_addr_i,
   input wire instr_ready_o,
   input wire [`BRSE_POINTS-1:0] field_out_o,
   input wire imm_out_we_o,
   input wire [`BRSE_ADDR_W-1:0] imm_out_addr_o,
   input wire imm_in_rd_o,
   input wire [`BRSE_ADDR_W-1:0] imm_in_addr_o,
   input wire stack_error_o,
   input wire scan_done_o,
   input wire executing_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (srst_i);
   // Instruction accepted at this edge, and the kind it carries
   wire take = instr_valid_i && instr_ready_o;
   wire is_imm = instr_op_i >= `BRSE_OP_IMM_LD && instr_op_i < `BRSE_OP_END;
   wire is_rd = is_imm && instr_op_i != `BRSE_OP_IMM_COIL;
   // Regular work needs one fetch cycle; immediate work stalls five
   sequence fetch_s;
      !instr_ready_o ##1 instr_ready_o;
   endsequence
   sequence imm_wait_s;
      !instr_ready_o [*5] ##1 instr_ready_o;
   endsequence
   sequence end_s;
      !instr_ready_o ##1 (scan_done_o && !instr_ready_o);
   endsequence
   fetch_gap_a: assert property (take && instr_op_i < `BRSE_OP_IMM_LD |=> fetch_s)
      else $error("regular instruction did not take two cycles");
   imm_stall_a: assert property (take && is_imm |=> imm_wait_s)
      else $error("immediate instruction stall length wrong");
   imm_read_a: assert property (take && is_rd |=>
      imm_in_rd_o && imm_in_addr_o == $past(instr_addr_i))
      else $error("immediate contact did not read its point");
   imm_write_a: assert property (take && instr_op_i == `BRSE_OP_IMM_COIL |=>
      imm_out_we_o && imm_out_addr_o == $past(instr_addr_i))
      else $error("immediate coil did not write its point");
   imm_in_exec_a: assert property (imm_in_rd_o || imm_out_we_o |-> executing_o)
      else $error("point access outside execution");
   out_phase_a: assert property (!$stable(field_out_o) |-> !executing_o)
      else $error("outputs changed during execution");
   end_done_a: assert property (take && instr_op_i == `BRSE_OP_END |=> end_s)
      else $error("program end did not close the scan");
   idle_quiet_a: assert property (!executing_o |-> !instr_ready_o)
      else $error("instruction accepted outside execution");
   err_clear_a: assert property ($fell(stack_error_o) |->
      $past(scan_start_i) || $past(scan_start_i, 2))
      else $error("stack error cleared without scan start");
endmodule // brse_evaluator_chk
`default_nettype wire

// ### verification/brse_field_model.sv
// Field point model: input levels and physical output latches
`timescale 1ns/1ps
`default_nettype none
`include "brse_defines.vh"
module brse_field_model (
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic [`BRSE_POINTS-1:0] pattern_i,
   input wire logic [`BRSE_POINTS-1:0] field_out_i,
   input wire logic imm_out_we_i,
   input wire logic [`BRSE_ADDR_W-1:0] imm_out_addr_i,
   input wire logic imm_out_data_i,
   output var logic [`BRSE_POINTS-1:0] field_in_o,
   output var logic [`BRSE_POINTS-1:0] phys_o
);
   logic [`BRSE_POINTS-1:0] last_out;
   // Inputs lag the request by a clock; output latches see both paths
   always @(posedge clock_i) begin
      field_in_o <= pattern_i;
      last_out <= field_out_i;
      if (srst_i)
         phys_o <= '0;
      else if (imm_out_we_i)
         phys_o[imm_out_addr_i] <= imm_out_data_i;
      else if (field_out_i != last_out)
         phys_o <= field_out_i;
   end
endmodule // brse_field_model
`default_nettype wire

// ### verification/tb_boolean_rung_stack_evaluator.sv
// Bench: evaluator against a queue model of the rung stack
`timescale 1ns/1ps
`default_nettype none
`include "brse_defines.vh"
module tb_boolean_rung_stack_evaluator;
   logic clock_i, srst_i, scan_start_i, instr_valid_i, rung_start_i;
   logic [`BRSE_OP_W-1:0] instr_op_i;
   logic [`BRSE_MOD_W-1:0] instr_mod_i;
   logic [`BRSE_ADDR_W-1:0] instr_addr_i, imm_out_addr_o, imm_in_addr_o;
   logic [`BRSE_VAL_W-1:0] cmp_a_i, cmp_b_i;
   logic [`BRSE_POINTS-1:0] field_in_i, field_out_o, phys, pat, fin, img, pout;
   logic instr_ready_o, imm_out_we_o, imm_out_data_o, imm_in_rd_o, err;
   logic rung_result_o, stack_error_o, scan_done_o, executing_o;
   logic stk[$];
   logic [3:0] ops [8] = '{`BRSE_OP_LD_OPEN, `BRSE_OP_SER, `BRSE_OP_SER_NOT,
      `BRSE_OP_PAR, `BRSE_OP_PAR_NOT, `BRSE_OP_IMM_LD, `BRSE_OP_IMM_SER,
      `BRSE_OP_IMM_PAR};
   logic [31:0] seed = 32'h858D7D9F;
   int checks = 0;
   int miscompares = 0;
   brse_evaluator DUT (.clock_i, .srst_i, .scan_start_i, .instr_valid_i,
      .instr_op_i, .instr_mod_i, .instr_addr_i, .rung_start_i, .cmp_a_i,
      .cmp_b_i, .field_in_i, .instr_ready_o, .field_out_o, .imm_out_we_o,
      .imm_out_addr_o, .imm_out_data_o, .imm_in_rd_o, .imm_in_addr_o,
      .rung_result_o, .stack_error_o, .scan_done_o, .executing_o);
   brse_field_model u_field (.clock_i, .srst_i, .pattern_i(pat),
      .field_out_i(field_out_o), .imm_out_we_i(imm_out_we_o),
      .imm_out_addr_i(imm_out_addr_o), .imm_out_data_i(imm_out_data_o),
      .field_in_o(field_in_i), .phys_o(phys));
   // Free-running 40 MHz clock
   initial begin
      clock_i = 1'b0;
      forever #12.5 clock_i = ~clock_i;
   end
   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction
   task automatic check(input logic ok, input string what);
      checks++;
      if (ok !== 1'b1) begin
         miscompares++;
         $display("FAIL %0t %s", $time, what);
      end
   endtask
   task automatic conclude();
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Depth beyond eight drops the bottom entry and flags the scan
   task automatic push(input logic v);
      stk.push_front(v);
      if (stk.size() > `BRSE_DEPTH) begin
         void'(stk.pop_back());
         err = 1'b1;
      end
   endtask
   // Valid stays up between instructions, so no double drive per edge
   task automatic issue(input logic [3:0] op, input logic [1:0] md,
         input logic [5:0] ad, input logic rs);
      int n;
      instr_valid_i <= 1'b1;
      instr_op_i <= op;
      instr_mod_i <= md;
      instr_addr_i <= ad;
      rung_start_i <= rs;
      n = 0;
      do begin
         @(negedge clock_i);
         n++;
      end while (instr_ready_o !== 1'b1 && n < 40);
      if (n >= 40) begin
         check(1'b0, "ready timeout");
         conclude();
      end
      @(posedge clock_i);
   endtask
   task automatic op_do(input logic [3:0] op, input logic [1:0] md,
         input logic [5:0] ad, input logic rs);
      logic c;
      logic t;
      if (rs)
         stk.delete();
      c = (op >= `BRSE_OP_IMM_LD) ? fin[ad] ^ md[0] : img[ad];
      t = 1'b0;
      if (op == `BRSE_OP_PAR_MERGE || op == `BRSE_OP_SER_MERGE)
         t = stk.pop_front();
      case (op)
         `BRSE_OP_LD_OPEN, `BRSE_OP_IMM_LD: push(c);
         `BRSE_OP_LD_CLOSED: push(!c);
         `BRSE_OP_SER, `BRSE_OP_IMM_SER: stk[0] &= c;
         `BRSE_OP_SER_NOT: stk[0] &= !c;
         `BRSE_OP_PAR, `BRSE_OP_IMM_PAR: stk[0] |= c;
         `BRSE_OP_PAR_NOT: stk[0] |= !c;
         `BRSE_OP_PAR_MERGE: stk[0] |= t;
         `BRSE_OP_SER_MERGE: stk[0] &= t;
         `BRSE_OP_COIL: img[ad] = stk[0];
         `BRSE_OP_IMM_COIL: begin
            img[ad] = stk[0];
            pout[ad] = stk[0];
         end
         `BRSE_OP_CMP: push(md == `BRSE_REL_EQ ? cmp_a_i == cmp_b_i :
            md == `BRSE_REL_NE ? cmp_a_i != cmp_b_i :
            md == `BRSE_REL_GE ? cmp_a_i >= cmp_b_i : cmp_a_i < cmp_b_i);
         default: ;
      endcase
      issue(op, md, ad, rs);
   endtask
   // Kinds: 0 random rungs, 1 comparisons, 2 stack overflow
   task automatic scan(input int kind);
      int r, k, n;
      logic [3:0] o;
      @(posedge clock_i);
      scan_start_i <= 1'b1;
      @(posedge clock_i);
      scan_start_i <= 1'b0;
      img = fin;
      err = 1'b0;
      for (r = 0; r < 12; r++) begin
         if (kind == 1) begin
            cmp_b_i <= r < 4 ? 16'h1234 : r < 8 ? 16'h1235 : 16'h0999;
            @(posedge clock_i);
            op_do(`BRSE_OP_CMP, 2'(r), 6'(r), 1'b1);
            op_do(`BRSE_OP_COIL, 2'h0, 6'(r), 1'b0);
         end else if (kind == 2) begin
            for (k = 0; k < 9; k++)
               op_do(`BRSE_OP_LD_OPEN, 2'h0, 6'(k), k == 0);
            for (k = 0; k < 7; k++)
               op_do(`BRSE_OP_SER_MERGE, 2'h0, 6'h0, 1'b0);
            op_do(`BRSE_OP_COIL, 2'h0, 6'(r + 40), 1'b0);
         end else begin
            o = rnd() % 2 ? `BRSE_OP_LD_OPEN : `BRSE_OP_LD_CLOSED;
            op_do(o, 2'h0, 6'(rnd()), 1'b1);
            for (k = 0; k < 5; k++) begin
               o = ops[rnd() % 8];
               if (o inside {`BRSE_OP_LD_OPEN, `BRSE_OP_IMM_LD} && stk.size() == 8)
                  o = `BRSE_OP_SER;
               op_do(o, 2'(rnd()), 6'(rnd()), 1'b0);
            end
            while (stk.size() > 1) begin
               o = rnd() % 2 ? `BRSE_OP_PAR_MERGE : `BRSE_OP_SER_MERGE;
               op_do(o, 2'h0, 6'h0, 1'b0);
            end
            o = rnd() % 2 ? `BRSE_OP_COIL : `BRSE_OP_IMM_COIL;
            op_do(o, 2'h0, 6'(rnd()), 1'b0);
            op_do(`BRSE_OP_SER, 2'h0, 6'(rnd()), 1'b0);
            op_do(`BRSE_OP_COIL, 2'h0, 6'(rnd()), 1'b0);
         end
         // Result seen one cycle after the stack moves, so read after a NOP
         issue(`BRSE_OP_NOP, 2'h0, 6'h0, 1'b0);
         @(negedge clock_i);
         check(rung_result_o === stk[0], "rung result");
         check(phys === pout, "immediate out");
         @(posedge clock_i);
         fin = {rnd(), rnd()};
         pat <= fin;
      end
      op_do(`BRSE_OP_END, 2'h0, 6'h0, 1'b0);
      instr_valid_i <= 1'b0;
      n = 0;
      while (scan_done_o !== 1'b1 && n < 20) begin
         @(negedge clock_i);
         n++;
      end
      check(n < 20, "scan done missing");
      if (n >= 20)
         conclude();
      repeat (3) @(posedge clock_i);
      check(field_out_o === img, "outputs");
      check(phys === img, "field points");
      check(stack_error_o === err, "stack error");
      pout = img;
   endtask
   // Main sequence
   initial begin
      srst_i = 1'b1;
      scan_start_i = 1'b0;
      instr_valid_i = 1'b0;
      rung_start_i = 1'b0;
      instr_op_i = `BRSE_OP_NOP;
      instr_mod_i = 2'h0;
      instr_addr_i = 6'h0;
      cmp_a_i = 16'h1234;
      cmp_b_i = 16'h0000;
      fin = '0;
      pat = '0;
      pout = '0;
      img = '0;
      repeat (4) @(posedge clock_i);
      srst_i <= 1'b0;
      check(field_out_o === '0 && stack_error_o === 1'b0, "reset");
      fin = {rnd(), rnd()};
      pat <= fin;
      scan(1);
      scan(2);
      repeat (6) scan(0);
      conclude();
   end
endmodule // tb_boolean_rung_stack_evaluator
bind brse_evaluator brse_evaluator_chk u_chk (.clock_i, .srst_i,
   .scan_start_i, .instr_valid_i, .instr_op_i, .instr_addr_i, .instr_ready_o,
   .field_out_o, .imm_out_we_o, .imm_out_addr_o, .imm_in_rd_o, .imm_in_addr_o,
   .stack_error_o, .scan_done_o, .executing_o);
`default_nettype wire
